// ===== timer16_capture_compare.sv
// Summary of operation
// - Filter on: capture reacts four system clocks later than unfiltered.
// - Filter and edge input active except when capture register sets top.
// - Software driving the capture pin port produces captures too.
// - Filter output changes only after four equal consecutive samples.
// - Filter enable bit in control register; clear means bypass.
// - Filter samples on system clock, independent of prescaler.
// - Every capture overwrites the capture register unconditionally.
// - Compare counter with compare register; flag set on next timer tick.
// - Enabled flag requests interrupt; clears on service or write one.
// - Compare A can be the counter top value.
// - PWM modes double-buffer compare, updated at top; others unbuffered.
// - Buffered: CPU reaches buffer; unbuffered: active compare register.
// - Compare reads return both bytes directly, no temporary register.
// - High byte into temp; low write copies temp to upper byte.
// - Force strobe in non-PWM updates output only, no flag, no reload.
// - Counter write blocks compare matches in the next timer tick.
// - Counter written to variable top misses top, runs to 0xffff.
// - Compare output state kept across waveform mode changes.
// - Output mode bits unbuffered, effective immediately.
// - Capture edge copies counter and sets flag in same cycle.
// - Select bit switches capture source to comparator output.
// - Capture low read latches high byte into temp for later read.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module timer16_capture_compare
  import capture_compare_pkg::*;
#(
  parameter int FILTER_LEN = capture_compare_pkg::FILTER_SAMPLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic        timer_tick,
  input  wire logic        capture_pin,
  input  wire logic        comparator_output,
  input  wire logic        capture_irq_ack,
  input  wire logic [1:0]  compare_irq_ack,
  output logic             capture_irq,
  output logic [1:0]       compare_irq,
  output logic [1:0]       compare_output_state
);
  import capture_compare_pkg::*;

  if (FILTER_LEN < 2 || FILTER_LEN > 16) begin : g_bad_filter_len
    $error("FILTER_LEN out of range");
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        aw_have_q, w_have_q, aw_have_d, w_have_d, bvalid_d, rvalid_d;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire, rd_take;
  logic [31:0] rd_word;
  logic        rd_mapped, wr_mapped;
  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_take = arvalid && arready_q;
  assign wr_mapped = (aw_addr_q[1:0] == 2'b00) && (aw_addr_q <= OFS_COMPARE_B_HI);
  assign rd_mapped = (araddr[1:0] == 2'b00) && (araddr <= OFS_COMPARE_B_HI);

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    bvalid_d  = bvalid_q;
    rvalid_d  = rvalid_q;
    if (awvalid && awready_q) begin
      aw_have_d = 1'b1;
    end
    if (wvalid && wready_q) begin
      w_have_d = 1'b1;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
    end
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (rd_take) begin
      rvalid_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q  <= !w_have_d && !bvalid_d;
      arready_q <= !rvalid_d;
      if (awvalid && awready_q) begin
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (rd_take) begin
        rdata_q <= rd_mapped ? rd_word : 32'h0000_0000;
        rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // Byte registers need lane 0; other lanes alone are ignored
  logic wr_byte;
  assign wr_byte = wr_fire && w_strb_q[0];

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction : wr_at

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [31:0] control_q;
  logic [3:0]  mode;
  logic        pwm;
  logic [1:0]  out_mode [2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= CONTROL_RESET;
    end else if (wr_fire && wr_at(aw_addr_q, OFS_CONTROL)) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          control_q[8*b +: 8] <= w_data_q[8*b +: 8];
        end
      end
    end
  end

  assign mode        = control_q[CTL_MODE_LSB +: 4];
  assign pwm         = mode_is_pwm(mode);
  assign out_mode[0] = control_q[CTL_OUT_MODE_LSB +: 2];
  assign out_mode[1] = control_q[CTL_OUT_MODE_LSB + 2 +: 2];

  // ----------------------------------------------------------------
  // Shared high-byte temporary and counter
  // ----------------------------------------------------------------
  logic [7:0]  temp_q;
  logic [15:0] counter_q, capture_q, top_value;
  logic [15:0] cmp_act_q [2];
  logic [15:0] cmp_buf_q [2];
  logic        block_q, counter_wr, top_hit, tick_live;

  assign counter_wr = wr_byte && wr_at(aw_addr_q, OFS_COUNTER_LO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_q <= 8'h00;
    end else if (wr_byte && (wr_at(aw_addr_q, OFS_COUNTER_HI) || wr_at(aw_addr_q, OFS_CAPTURE_HI) ||
                 wr_at(aw_addr_q, OFS_COMPARE_A_HI) || wr_at(aw_addr_q, OFS_COMPARE_B_HI))) begin
      temp_q <= w_data_q[7:0];
    end else if (rd_take && araddr == OFS_CAPTURE_LO) begin
      temp_q <= capture_q[15:8];
    end else if (rd_take && araddr == OFS_COUNTER_LO) begin
      temp_q <= counter_q[15:8];
    end
  end

  always_comb begin
    if (top_from_compare_a(mode)) begin
      top_value = cmp_act_q[0];
    end else if (top_from_capture(mode)) begin
      top_value = capture_q;
    end else if (mode == 4'd1 || mode == 4'd5) begin
      top_value = TOP_8BIT;
    end else if (mode == 4'd2 || mode == 4'd6) begin
      top_value = TOP_9BIT;
    end else if (mode == 4'd3 || mode == 4'd7) begin
      top_value = TOP_10BIT;
    end else begin
      top_value = COUNT_MAX;
    end
  end

  // Blocked tick keeps counting past a written top value
  assign tick_live = timer_tick && !block_q;
  assign top_hit   = tick_live && (counter_q == top_value);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_q <= 16'h0000;
      block_q   <= 1'b0;
    end else if (counter_wr) begin
      counter_q <= {temp_q, w_data_q[7:0]};
      block_q   <= 1'b1;
    end else if (timer_tick) begin
      counter_q <= top_hit ? 16'h0000 : counter_q + 16'h0001;
      block_q   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Capture front end
  // ----------------------------------------------------------------
  logic                  sample_q, filt_q, prev_q, level, cap_event;
  logic [FILTER_LEN-2:0] hist_q;
  logic [FILTER_LEN-1:0] window;
  logic                  cap_flag_q, cap_irq_q;

  // Pin is sampled as is, so a port-driven level captures as well
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_q <= 1'b0;
      hist_q   <= '0;
      filt_q   <= 1'b0;
      prev_q   <= 1'b0;
    end else begin
      sample_q <= control_q[CTL_COMP_SEL_BIT] ? comparator_output : capture_pin;
      hist_q   <= window[FILTER_LEN-2:0];
      if (&window) begin
        filt_q <= 1'b1;
      end else if (~|window) begin
        filt_q <= 1'b0;
      end
      prev_q <= level;
    end
  end

  assign window = {hist_q, sample_q};
  // Filtered path lags the bypass by exactly FILTER_LEN clocks
  assign level  = control_q[CTL_FILTER_BIT] ? filt_q : sample_q;
  assign cap_event = !top_from_capture(mode) &&
                     (control_q[CTL_EDGE_BIT] ? (level && !prev_q) : (!level && prev_q));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_q <= 16'h0000;
    end else if (cap_event) begin
      capture_q <= counter_q;
    end else if (wr_byte && wr_at(aw_addr_q, OFS_CAPTURE_LO) && top_from_capture(mode)) begin
      capture_q <= {temp_q, w_data_q[7:0]};
    end
  end

  // Set beats a simultaneous clear or acknowledge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_flag_q <= 1'b0;
      cap_irq_q  <= 1'b0;
    end else begin
      if (cap_event) begin
        cap_flag_q <= 1'b1;
      end else if (capture_irq_ack ||
                   (wr_fire && wr_at(aw_addr_q, OFS_STATUS) && w_strb_q[0] && w_data_q[STS_CAP_FLAG_BIT])) begin
        cap_flag_q <= 1'b0;
      end
      cap_irq_q <= cap_flag_q && control_q[CTL_CAP_IRQ_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------
  logic [1:0] cmp_flag_q, cmp_irq_q, oc_q;
  logic [7:0] cmp_lo_ofs [2];
  assign cmp_lo_ofs[0] = OFS_COMPARE_A_LO;
  assign cmp_lo_ofs[1] = OFS_COMPARE_B_LO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 2; i++) begin
        cmp_act_q[i] <= 16'h0000;
        cmp_buf_q[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_byte && wr_at(aw_addr_q, cmp_lo_ofs[i])) begin
          if (pwm) begin
            cmp_buf_q[i] <= {temp_q, w_data_q[7:0]};
          end else begin
            cmp_act_q[i] <= {temp_q, w_data_q[7:0]};
          end
        end else if (pwm && top_hit) begin
          cmp_act_q[i] <= cmp_buf_q[i];
        end
      end
    end
  end

  logic [1:0] force_req, match_hit, flag_clr;
  assign force_req = (wr_fire && wr_at(aw_addr_q, OFS_STATUS) && w_strb_q[0] && !pwm) ?
                     w_data_q[STS_FORCE_LSB +: 2] : 2'b00;
  assign flag_clr  = (wr_fire && wr_at(aw_addr_q, OFS_STATUS) && w_strb_q[0]) ?
                     w_data_q[STS_CMP_FLAG_LSB +: 2] : 2'b00;

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      match_hit[i] = tick_live && (counter_q == cmp_act_q[i]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_flag_q <= 2'b00;
      cmp_irq_q  <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (match_hit[i]) begin
          cmp_flag_q[i] <= 1'b1;
        end else if (compare_irq_ack[i] || flag_clr[i]) begin
          cmp_flag_q[i] <= 1'b0;
        end
        cmp_irq_q[i] <= cmp_flag_q[i] && control_q[CTL_CMP_IRQ_LSB + i];
      end
    end
  end

  // Output state only changes on its own events, never on mode switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!pwm && (match_hit[i] || force_req[i])) begin
          unique case (output_mode_type'(out_mode[i]))
            out_none:   oc_q[i] <= oc_q[i];
            out_toggle: oc_q[i] <= !oc_q[i];
            out_clear:  oc_q[i] <= 1'b0;
            out_set:    oc_q[i] <= 1'b1;
          endcase
        end else if (pwm && match_hit[i] && out_mode[i][1]) begin
          oc_q[i] <= out_mode[i][0];
        end else if (pwm && top_hit && out_mode[i][1]) begin
          oc_q[i] <= !out_mode[i][0];
        end
      end
    end
  end

  assign capture_irq          = cap_irq_q;
  assign compare_irq          = cmp_irq_q;
  assign compare_output_state = oc_q;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (araddr)
      OFS_CONTROL:      rd_word = control_q;
      OFS_STATUS:       rd_word = {22'h0, oc_q, 5'h0, cmp_flag_q, cap_flag_q};
      OFS_COUNTER_LO:   rd_word = {24'h0, counter_q[7:0]};
      OFS_COUNTER_HI:   rd_word = {24'h0, temp_q};
      OFS_CAPTURE_LO:   rd_word = {24'h0, capture_q[7:0]};
      OFS_CAPTURE_HI:   rd_word = {24'h0, temp_q};
      OFS_COMPARE_A_LO: rd_word = {24'h0, pwm ? cmp_buf_q[0][7:0] : cmp_act_q[0][7:0]};
      OFS_COMPARE_A_HI: rd_word = {24'h0, pwm ? cmp_buf_q[0][15:8] : cmp_act_q[0][15:8]};
      OFS_COMPARE_B_LO: rd_word = {24'h0, pwm ? cmp_buf_q[1][7:0] : cmp_act_q[1][7:0]};
      OFS_COMPARE_B_HI: rd_word = {24'h0, pwm ? cmp_buf_q[1][15:8] : cmp_act_q[1][15:8]};
      default:          rd_word = 32'h0000_0000;
    endcase
  end

endmodule : timer16_capture_compare

// ===== capture_compare_pkg.sv
package capture_compare_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL      = 8'h00;
  localparam logic [7:0] OFS_STATUS       = 8'h04;
  localparam logic [7:0] OFS_COUNTER_LO   = 8'h08;
  localparam logic [7:0] OFS_COUNTER_HI   = 8'h0c;
  localparam logic [7:0] OFS_CAPTURE_LO   = 8'h10;
  localparam logic [7:0] OFS_CAPTURE_HI   = 8'h14;
  localparam logic [7:0] OFS_COMPARE_A_LO = 8'h18;
  localparam logic [7:0] OFS_COMPARE_A_HI = 8'h1c;
  localparam logic [7:0] OFS_COMPARE_B_LO = 8'h20;
  localparam logic [7:0] OFS_COMPARE_B_HI = 8'h24;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTL_MODE_LSB      = 0;
  localparam int CTL_FILTER_BIT    = 4;
  localparam int CTL_EDGE_BIT      = 5;
  localparam int CTL_COMP_SEL_BIT  = 6;
  localparam int CTL_OUT_MODE_LSB  = 8;
  localparam int CTL_CMP_IRQ_LSB   = 12;
  localparam int CTL_CAP_IRQ_BIT   = 14;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int STS_CAP_FLAG_BIT  = 0;
  localparam int STS_CMP_FLAG_LSB  = 1;
  localparam int STS_FORCE_LSB     = 4;
  localparam int STS_OC_LSB        = 8;

  // ----------------------------------------------------------------
  // Timing and fixed values
  // ----------------------------------------------------------------
  localparam int          FILTER_SAMPLES = 4;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam logic [15:0] TOP_8BIT       = 16'h00ff;
  localparam logic [15:0] TOP_9BIT       = 16'h01ff;
  localparam logic [15:0] TOP_10BIT      = 16'h03ff;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    out_none,
    out_toggle,
    out_clear,
    out_set
  } output_mode_type;

  function automatic logic mode_is_pwm(input logic [3:0] m);
    return !(m == 4'd0 || m == 4'd4 || m == 4'd12 || m == 4'd13);
  endfunction : mode_is_pwm

  function automatic logic top_from_capture(input logic [3:0] m);
    return (m == 4'd8 || m == 4'd10 || m == 4'd12 || m == 4'd14);
  endfunction : top_from_capture

  function automatic logic top_from_compare_a(input logic [3:0] m);
    return (m == 4'd4 || m == 4'd9 || m == 4'd11 || m == 4'd15);
  endfunction : top_from_compare_a

endpackage : capture_compare_pkg

// ===== timer16_capture_compare_monitor.sv
`timescale 1ns/1ps
module timer16_capture_compare_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        timer_tick,
  input wire logic        capture_irq_ack,
  input wire logic [1:0]  compare_irq_ack,
  input wire logic        capture_irq,
  input wire logic [1:0]  compare_irq,
  input wire logic [1:0]  compare_output_state
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // Bus and event checks
  // ------------------------------------------------------------
  a_wresp_held: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  a_out_has_cause: assert property ($changed(compare_output_state) |-> $past(timer_tick) || $rose(bvalid))
    else $error("output state changed without tick or write");
  a_cmp_irq_cause: assert property ($rose(compare_irq[0]) |-> $past(timer_tick, 2) || $past(bvalid))
    else $error("compare request without tick");
  a_cmp_irq_clear: assert property ($fell(compare_irq[0]) |-> $past(compare_irq_ack[0], 2) || $past(bvalid))
    else $error("compare request dropped without service");
  a_cap_irq_clear: assert property ($fell(capture_irq) |-> $past(capture_irq_ack, 2) || $past(bvalid))
    else $error("capture request dropped without service");
  c_capture: cover property ($rose(capture_irq));
  c_service: cover property (compare_irq[0] && compare_irq_ack[0]);
  c_force: cover property ($changed(compare_output_state) && !$past(timer_tick));
endmodule : timer16_capture_compare_monitor

bind timer16_capture_compare timer16_capture_compare_monitor mon_u (
  .aclk(aclk), .aresetn(aresetn), .awready(awready), .wready(wready), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .timer_tick(timer_tick), .capture_irq_ack(capture_irq_ack), .compare_irq_ack(compare_irq_ack),
  .capture_irq(capture_irq), .compare_irq(compare_irq), .compare_output_state(compare_output_state)
);

// ===== irq_service_model.sv
`timescale 1ns/1ps
module irq_service_model #(
  parameter int DELAY = 3
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       enable,
  input  wire logic       capture_irq,
  input  wire logic [1:0] compare_irq,
  output logic            capture_irq_ack,
  output logic [1:0]      compare_irq_ack
);
  int wait_q;
  // Gap after each service stops a second ack before the request falls
  always_ff @(posedge aclk) begin
    capture_irq_ack <= 1'b0;
    compare_irq_ack <= 2'b00;
    if (!aresetn || !enable) begin
      wait_q <= 0;
    end else if (wait_q < DELAY) begin
      wait_q <= wait_q + 1;
    end else if (capture_irq) begin
      capture_irq_ack <= 1'b1;
      wait_q          <= 0;
    end else if (compare_irq != 2'b00) begin
      compare_irq_ack <= compare_irq[0] ? 2'b01 : 2'b10;
      wait_q          <= 0;
    end
  end
endmodule : irq_service_model

// ===== timer16_capture_compare_tb_top.sv
`timescale 1ns/1ps
module timer16_capture_compare_tb_top;
  import capture_compare_pkg::*;
  localparam int FL = 4;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, timer_tick = 1'b0, capture_pin = 1'b0, comparator_output = 1'b0, svc_en = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, capture_irq, capture_irq_ack;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp, compare_irq, compare_irq_ack, compare_output_state;
  int errors = 0, n_tests = 0;

  always #12.5 aclk = ~aclk;

  timer16_capture_compare #(.FILTER_LEN(FL)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .timer_tick(timer_tick), .capture_pin(capture_pin), .comparator_output(comparator_output),
    .capture_irq_ack(capture_irq_ack), .compare_irq_ack(compare_irq_ack), .capture_irq(capture_irq),
    .compare_irq(compare_irq), .compare_output_state(compare_output_state)
  );

  irq_service_model #(.DELAY(3)) svc_u (
    .aclk(aclk), .aresetn(aresetn), .enable(svc_en), .capture_irq(capture_irq), .compare_irq(compare_irq),
    .capture_irq_ack(capture_irq_ack), .compare_irq_ack(compare_irq_ack)
  );

  // ------------------------------------------------------------
  // Bus and check helpers
  // ------------------------------------------------------------
  task automatic final_report();
    $display("comparisons=%0d errors=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int  n;
    logic pa, pw, pb;
    n = 0;
    {pa, pw, pb} = 3'b111;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (pa || pw || pb) begin
      @(posedge aclk);
      n++;
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (pb && bvalid && bready) begin
        pb = 1'b0;
        bready <= 1'b0;
      end else if (pb && bvalid) begin
        bready <= 1'b1;
      end
      if (n > 50) begin
        errors++;
        final_report();
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int  n;
    logic pa, pr;
    n = 0;
    {pa, pr} = 2'b11;
    araddr  <= a;
    arvalid <= 1'b1;
    while (pa || pr) begin
      @(posedge aclk);
      n++;
      if (pa && arready) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
      if (pr && rvalid && rready) begin
        pr = 1'b0;
        rready <= 1'b0;
        d = rdata;
        r = rresp;
      end else if (pr && rvalid) begin
        rready <= 1'b1;
      end
      if (n > 50) begin
        errors++;
        final_report();
      end
    end
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, exp);
  endtask : rc

  // High byte goes to the shared temporary first
  task automatic w16(input logic [7:0] lo, input logic [15:0] v);
    wr(lo + 8'h04, {24'h0, v[15:8]});
    wr(lo, {24'h0, v[7:0]});
  endtask : w16

  task automatic ticks(input int k);
    repeat (k) begin
      timer_tick <= 1'b1;
      @(posedge aclk);
      timer_tick <= 1'b0;
      @(posedge aclk);
    end
  endtask : ticks

  // Edges until the capture request shows, seen the same way every time
  task automatic wait_cap(output int n);
    n = 0;
    while (capture_irq !== 1'b1 && n < 60) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 60) begin
      errors++;
      final_report();
    end
  endtask : wait_cap

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rc(OFS_CONTROL, CONTROL_RESET);
    rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0);
    chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
  endtask : s_regs

  task automatic s_compare();
    int n;
    wr(OFS_CONTROL, 32'h0000_1100);
    w16(OFS_COMPARE_A_LO, 16'h0103);
    rc(OFS_COMPARE_A_LO, 32'h03);
    rc(OFS_COMPARE_A_HI, 32'h01);
    w16(OFS_COUNTER_LO, 16'h0103);
    ticks(1);
    rc(OFS_STATUS, 32'h0);
    w16(OFS_COUNTER_LO, 16'h0101);
    ticks(2);
    rc(OFS_STATUS, 32'h0);
    ticks(1);
    rc(OFS_STATUS, 32'h102);
    chk({30'h0, compare_irq}, 32'h1);
    svc_en <= 1'b1;
    n = 0;
    while (compare_irq[0] !== 1'b0 && n < 50) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 50) begin
      errors++;
      final_report();
    end
    svc_en <= 1'b0;
    rc(OFS_STATUS, 32'h100);
  endtask : s_compare

  // Old active value must still match while the new one sits in the buffer
  task automatic s_pwm();
    wr(OFS_CONTROL, 32'h0000_0107);
    rc(OFS_STATUS, 32'h100);
    w16(OFS_COMPARE_A_LO, 16'h0010);
    rc(OFS_COMPARE_A_LO, 32'h10);
    wr(OFS_STATUS, 32'h10);
    w16(OFS_COUNTER_LO, 16'h0101);
    ticks(3);
    rc(OFS_STATUS, 32'h102);
    wr(OFS_STATUS, 32'h6);
    wr(OFS_CONTROL, 32'h0000_0200);
    rc(OFS_STATUS, 32'h100);
    wr(OFS_STATUS, 32'h10);
    rc(OFS_STATUS, 32'h0);
    chk({30'h0, compare_output_state}, 32'h0);
  endtask : s_pwm

  task automatic s_capture();
    int lu, lf;
    wr(OFS_CONTROL, 32'h0000_4020);
    w16(OFS_COUNTER_LO, 16'h1234);
    capture_pin <= 1'b1;
    wait_cap(lu);
    rc(OFS_CAPTURE_LO, 32'h34);
    rc(OFS_CAPTURE_HI, 32'h12);
    rc(OFS_STATUS, 32'h1);
    wr(OFS_STATUS, 32'h1);
    capture_pin <= 1'b0;
    repeat (10) @(posedge aclk);
    rc(OFS_STATUS, 32'h0);
    wr(OFS_CONTROL, 32'h0000_4030);
    w16(OFS_COUNTER_LO, 16'h5678);
    capture_pin <= 1'b1;
    wait_cap(lf);
    chk(lf - lu, FL);
    rc(OFS_CAPTURE_LO, 32'h78);
    wr(OFS_STATUS, 32'h1);
    capture_pin <= 1'b0;
    repeat (3) @(posedge aclk);
    capture_pin <= 1'b1;
    repeat (12) @(posedge aclk);
    rc(OFS_STATUS, 32'h0);
    wr(OFS_CONTROL, 32'h0000_4060);
    wr(OFS_STATUS, 32'h1);
    rc(OFS_STATUS, 32'h0);
    comparator_output <= 1'b1;
    wait_cap(lu);
    rc(OFS_STATUS, 32'h1);
    wr(OFS_CONTROL, 32'h0000_406c);
    wr(OFS_STATUS, 32'h1);
    comparator_output <= 1'b0;
    repeat (4) @(posedge aclk);
    comparator_output <= 1'b1;
    repeat (10) @(posedge aclk);
    rc(OFS_STATUS, 32'h0);
  endtask : s_capture

  task automatic s_top();
    wr(OFS_CONTROL, 32'h0000_000f);
    w16(OFS_COUNTER_LO, 16'h0103);
    ticks(1);
    rc(OFS_COUNTER_LO, 32'h04);
    rc(OFS_COUNTER_HI, 32'h01);
    w16(OFS_COUNTER_LO, 16'h0102);
    ticks(2);
    rc(OFS_COUNTER_LO, 32'h00);
    wr(OFS_CONTROL, 32'h0);
    rc(OFS_COMPARE_A_LO, 32'h10);
  endtask : s_top

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    s_regs();
    s_compare();
    s_pwm();
    s_capture();
    s_top();
    final_report();
  end
endmodule : timer16_capture_compare_tb_top
